// *** verilog/mrhx_hopper.sv ***
// memory request hopper: priority entry, re-issue loop and exchange sequencer
`timescale 1ns/1ps
`default_nettype none
module mrhx_hopper
  import mrhx_pkg::*;
#(
  parameter int ADDRW = ADDR_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // central processor request
  input wire logic cp_req,
  input wire logic [ADDRW-1:0] cp_addr,
  input wire logic [TAG_W-1:0] cp_fdes_tag,
  input wire logic cp_tag_from_cpu,
  input wire logic [TAG_W-1:0] cp_cpu_tag,
  output logic cp_grant,
  // peripheral processor request
  input wire logic pp_req,
  input wire logic pp_write,
  input wire logic [ADDRW-1:0] pp_addr,
  input wire logic pp_xchg_pulse,
  output logic pp_grant,
  output logic xchg_complete,
  // processor state
  input wire logic cpu_running,
  input wire logic issue,
  input wire logic [1:0] parcel_cnt,
  input wire logic reservations_busy,
  input wire logic [ADDRW-1:0] pc_value,
  output logic cpu_halt,
  output logic pc_to_word,
  output logic pc_load,
  // memory side
  output logic mem_go,
  output logic mem_req,
  output logic [MEM_ADDR_W-1:0] mem_addr,
  input wire logic mem_accept,
  // tag taps for exit control and translators
  output logic [TAG_W-1:0] tag_s4,
  output logic [TAG_W-1:0] tag_s3,
  output logic [TAG_W-1:0] tag_s2,
  output logic [ADDRW-1:0] pc_word_data
);
  localparam int SW = ADDRW + TAG_W + 1;

  logic pp_xchg_s1;
  logic pp_xchg_s2;
  logic pp_xchg_d;
  logic xchg_rise;

  mrhx_xstate_e xs_reg, xs_next;
  logic [CNT_W-1:0] tcnt_reg, tcnt_next;
  logic [CNT_W-1:0] icnt_reg, icnt_next;
  logic [ADDRW-1:0] in_reg, in_next;
  logic [ADDRW-1:0] xaddr_reg, xaddr_next;
  logic [TAG_W-1:0] xtag_reg, xtag_next;
  logic halt_reg, halt_next;
  logic done_reg, done_next;
  logic xload_reg, xload_next;
  logic [SW-1:0] s1_reg, s1_next;
  logic [CNT_W-1:0] rcnt_reg, rcnt_next;
  logic [SW-1:0] park_reg, park_next;
  logic park_valid;
  logic [SW-1:0] s4;
  logic [SW-1:0] s3;
  logic [SW-1:0] s2;
  logic s1_valid;
  logic s2_pending;
  logic queue_empty;
  logic [1:0] outstanding;
  logic room;
  logic shift;
  logic take_reissue;
  logic take_cp;
  logic take_pp;
  logic take_x;
  logic [TAG_W-1:0] cp_tag;
  logic pc_swap_next;
  logic pc_swap_reg;
  logic [ADDRW-1:0] pcw_reg;

  function automatic logic [SW-1:0] pack(input logic [ADDRW-1:0] a, input logic [TAG_W-1:0] t);
    pack = {1'b1, t, a};
  endfunction

  function automatic logic [TAG_W-1:0] tag_of(input logic [SW-1:0] s);
    tag_of = s[ADDRW+TAG_W-1:ADDRW];
  endfunction

  // the pulse arrives from another unit, so it is synchronised first
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pp_xchg_s1 <= 1'b0;
      pp_xchg_s2 <= 1'b0;
      pp_xchg_d <= 1'b0;
    end
    else
    begin
      pp_xchg_s1 <= pp_xchg_pulse;
      pp_xchg_s2 <= pp_xchg_s1;
      pp_xchg_d <= pp_xchg_s2;
    end
  end
  assign xchg_rise = pp_xchg_s2 & ~pp_xchg_d;

  mrhx_stage_mem #(.WIDTH(SW)) u_stages (
    .mclk(mclk),
    .rst_n(rst_n),
    .shift(shift),
    .din(s1_reg),
    .s4(s4),
    .s3(s3),
    .s2(s2)
  );

  // stage two's valid flag is not counted; an unaccepted copy is parked until its retry slot
  assign s1_valid = s1_reg[SW-1];
  assign s2_pending = s3[SW-1] & ~mem_accept;
  assign park_valid = park_reg[SW-1];
  assign outstanding = 2'(s1_valid) + 2'(s4[SW-1]) + 2'(s3[SW-1]);
  assign queue_empty = ~s1_valid & ~s4[SW-1] & ~s3[SW-1] & ~park_valid;
  // entry waits until the previous address is accepted: one parking slot then
  // never overflows, traded against back-to-back throughput
  assign room = (outstanding < 2'd3) && queue_empty;
  assign shift = 1'b1;

  assign cp_tag = cp_tag_from_cpu ? cp_cpu_tag : cp_fdes_tag;
  assign take_reissue = park_valid && (rcnt_reg == '0);
  assign take_x = ~take_reissue && xload_reg && room && (icnt_reg == '0);
  assign take_cp = ~take_reissue && ~halt_reg && cp_req && room;
  assign take_pp = ~take_reissue && ~take_cp && ~halt_reg && pp_req && room;
  assign cp_grant = take_cp;
  assign pp_grant = take_pp;

  // stage one entry and the re-issue interval
  always_comb
  begin
    s1_next = '0;
    park_next = park_reg;
    rcnt_next = (rcnt_reg == '0) ? '0 : rcnt_reg - 1'b1;
    // loaded in the issue cycle itself, so the retry lands one full interval later
    if (s1_valid)
      rcnt_next = CNT_W'(REISSUE_CYC - 2);
    if (take_reissue)
    begin
      s1_next = park_reg;
      park_next = '0;
    end
    else if (take_x)
      s1_next = pack(xaddr_reg, xtag_reg);
    else if (take_cp)
      s1_next = pack(cp_addr, cp_tag);
    else if (take_pp)
      s1_next = pack(pp_addr, pp_write ? TAG_PP_WRITE : TAG_PP_READ);
    if (s2_pending)
      park_next = s3;
  end

  // exchange sequencer
  always_comb
  begin
    xs_next = xs_reg;
    tcnt_next = tcnt_reg + 1'b1;
    icnt_next = (icnt_reg == '0) ? '0 : icnt_reg - 1'b1;
    in_next = in_reg;
    xaddr_next = xaddr_reg;
    xtag_next = xtag_reg;
    halt_next = halt_reg;
    done_next = 1'b0;
    xload_next = xload_reg;
    mem_go = 1'b0;
    unique case (xs_reg)
      XS_IDLE:
      begin
        tcnt_next = '0;
        if (xchg_rise)
        begin
          in_next = pp_addr;
          xs_next = XS_CAPTURE;
        end
      end
      XS_CAPTURE:
      begin
        if (tcnt_reg == CNT_W'(XFER_CYC - 1))
        begin
          xaddr_next = in_reg;
          xs_next = XS_HALT;
        end
      end
      XS_HALT:
      begin
        if (!cpu_running || (issue && parcel_cnt == PARCEL_ONE))
          halt_next = 1'b1;
        if (halt_reg && queue_empty && !reservations_busy && tcnt_reg >= CNT_W'(START_CYC - 1))
        begin
          tcnt_next = CNT_W'(START_CYC);
          xtag_next = XTAG_FIRST;
          xs_next = XS_START;
        end
        else if (tcnt_reg == CNT_W'(START_CYC - 1))
          tcnt_next = tcnt_reg;
      end
      XS_START:
      begin
        mem_go = (tcnt_reg == CNT_W'(GO_CYC));
        if (tcnt_reg == CNT_W'(LOAD_CYC - 1))
        begin
          xload_next = 1'b1;
          xs_next = XS_RUN;
        end
      end
      XS_RUN:
      begin
        if (take_x)
        begin
          icnt_next = CNT_W'(ISSUE_CYC - 1);
          if (xtag_reg == XTAG_LAST)
            xload_next = 1'b0;
          else
          begin
            xaddr_next = xaddr_reg + 1'b1;
            xtag_next = xtag_reg + 1'b1;
          end
        end
        if (!xload_reg && tcnt_reg >= CNT_W'(DONE_CYC - 1))
          xs_next = XS_DONE;
        else if (tcnt_reg >= CNT_W'(DONE_CYC - 1))
          tcnt_next = tcnt_reg;
      end
      XS_DONE:
      begin
        done_next = 1'b1;
        halt_next = 1'b0;
        xs_next = XS_IDLE;
      end
    endcase
  end

  // package first word: pc saved at bits 36-53 and reloaded on tag 60 with accept
  assign pc_swap_next = mem_accept && (tag_of(s3) == TAG_PC_SWAP) && s3[SW-1];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xs_reg <= XS_IDLE;
      tcnt_reg <= '0;
      icnt_reg <= '0;
      in_reg <= '0;
      xaddr_reg <= '0;
      xtag_reg <= '0;
      halt_reg <= 1'b0;
      done_reg <= 1'b0;
      xload_reg <= 1'b0;
      s1_reg <= '0;
      rcnt_reg <= '0;
      park_reg <= '0;
      pc_swap_reg <= 1'b0;
      pcw_reg <= '0;
    end
    else
    begin
      xs_reg <= xs_next;
      tcnt_reg <= tcnt_next;
      icnt_reg <= icnt_next;
      in_reg <= in_next;
      xaddr_reg <= xaddr_next;
      xtag_reg <= xtag_next;
      halt_reg <= halt_next;
      done_reg <= done_next;
      xload_reg <= xload_next;
      s1_reg <= s1_next;
      rcnt_reg <= rcnt_next;
      park_reg <= park_next;
      pc_swap_reg <= pc_swap_next;
      pcw_reg <= pc_swap_next ? pc_value : pcw_reg;
    end
  end

  // halt also covers a non-empty queue while a peripheral waits
  assign cpu_halt = halt_reg | (pp_req & ~room);
  assign xchg_complete = done_reg;
  assign mem_req = s1_valid;
  assign mem_addr = s1_reg[MEM_ADDR_W-1:0];
  assign tag_s4 = tag_of(s4);
  assign tag_s3 = tag_of(s3);
  assign tag_s2 = tag_of(s2);
  assign pc_to_word = pc_swap_reg;
  assign pc_load = pc_swap_reg;
  assign pc_word_data = pcw_reg;
endmodule
`default_nettype wire

// *** verilog/mrhx_pkg.sv ***
// package of constants and types for the memory request hopper with exchange sequencer
package mrhx_pkg;
  localparam int ADDR_W = 18;
  localparam int TAG_W = 6;
  localparam int MEM_ADDR_W = 17;
  localparam int STAGE_W = ADDR_W + TAG_W + 1;
  localparam int CLK_NS = 10;
  // timing figures in ns, counts derived from the clock period
  localparam int REISSUE_NS = 300;
  localparam int REISSUE_CYC = (REISSUE_NS + CLK_NS - 1) / CLK_NS;
  localparam int XFER_NS = 50;
  localparam int XFER_CYC = (XFER_NS + CLK_NS - 1) / CLK_NS;
  localparam int START_NS = 100;
  localparam int START_CYC = (START_NS + CLK_NS - 1) / CLK_NS;
  localparam int GO_NS = 165;
  localparam int GO_CYC = (GO_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_NS = 200;
  localparam int LOAD_CYC = (LOAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ISSUE_NS = 100;
  localparam int ISSUE_CYC = (ISSUE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DONE_NS = 1630;
  localparam int DONE_CYC = (DONE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  localparam logic [TAG_W-1:0] XTAG_FIRST = 6'h00;
  localparam logic [TAG_W-1:0] XTAG_LAST = 6'h0F;
  localparam logic [TAG_W-1:0] TAG_PC_SWAP = 6'h30;
  localparam logic [TAG_W-1:0] TAG_PP_READ = 6'h00;
  localparam logic [TAG_W-1:0] TAG_PP_WRITE = 6'h20;
  localparam logic [1:0] PARCEL_ONE = 2'h1;
  localparam int PC_LO = 36;
  localparam int PC_HI = 53;
  typedef enum logic [5:0] {
    XS_IDLE = 6'h01,
    XS_CAPTURE = 6'h02,
    XS_HALT = 6'h04,
    XS_START = 6'h08,
    XS_RUN = 6'h10,
    XS_DONE = 6'h20
  } mrhx_xstate_e;
endpackage

// *** verilog/mrhx_stage_mem.sv ***
// request queue stages two to four: shift store whose outputs come from registers
`timescale 1ns/1ps
`default_nettype none
module mrhx_stage_mem
  import mrhx_pkg::*;
#(
  parameter int WIDTH = STAGE_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // shift input from the first stage
  input wire logic shift,
  input wire logic [WIDTH-1:0] din,
  // stage contents
  output logic [WIDTH-1:0] s4,
  output logic [WIDTH-1:0] s3,
  output logic [WIDTH-1:0] s2
);
  logic [WIDTH-1:0] s4_next;
  logic [WIDTH-1:0] s3_next;
  logic [WIDTH-1:0] s2_next;

  always_comb
  begin
    s4_next = shift ? din : s4;
    s3_next = shift ? s4 : s3;
    s2_next = shift ? s3 : s2;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s4 <= '0;
      s3 <= '0;
      s2 <= '0;
    end
    else
    begin
      s4 <= s4_next;
      s3 <= s3_next;
      s2 <= s2_next;
    end
  end
endmodule
`default_nettype wire

// *** verif/mrhx_mem_model.sv ***
// memory bank model that answers stage-one requests with an accept
`timescale 1ns/1ps
`default_nettype none
module mrhx_mem_model
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // hopper side and bench command
  input wire logic mem_req,
  input wire logic reject,
  output logic mem_accept
);
  logic [1:0] pipe_reg;
  logic [1:0] pipe_next;
  always_comb
  begin
    pipe_next = {pipe_reg[0], mem_req};
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pipe_reg <= 2'h0;
    else
      pipe_reg <= pipe_next;
  end
  // answer while the address sits in stage three; reject plays a bank still busy
  assign mem_accept = pipe_reg[1] & ~reject;
endmodule
`default_nettype wire

// *** verif/mrhx_hopper_assertions.sv ***
// assertion checker on the hopper ports
`timescale 1ns/1ps
`default_nettype none
module mrhx_hopper_chk
  import mrhx_pkg::*;
#(
  parameter int ADDRW = ADDR_W
)
(
  // watched ports
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDRW-1:0] cp_addr,
  input wire logic [TAG_W-1:0] cp_fdes_tag,
  input wire logic cp_tag_from_cpu,
  input wire logic [TAG_W-1:0] cp_cpu_tag,
  input wire logic cp_grant,
  input wire logic pp_write,
  input wire logic pp_grant,
  input wire logic xchg_complete,
  input wire logic cpu_halt,
  input wire logic mem_go,
  input wire logic mem_req,
  input wire logic [MEM_ADDR_W-1:0] mem_addr,
  input wire logic [TAG_W-1:0] tag_s4,
  input wire logic [TAG_W-1:0] tag_s3,
  input wire logic [TAG_W-1:0] tag_s2
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  property p_cp_tag;
    logic [TAG_W-1:0] t;
    (cp_grant, t = cp_tag_from_cpu ? cp_cpu_tag : cp_fdes_tag)
      |-> ##2 tag_s4 == t ##1 tag_s3 == t ##1 tag_s2 == t;
  endproperty
  property p_pp_tag;
    logic w;
    (pp_grant, w = pp_write) |=> mem_req ##1 tag_s4 == (w ? TAG_PP_WRITE : TAG_PP_READ);
  endproperty
  AST_CP_TAG:
    assert property (p_cp_tag) else $error("central tag lost in queue");
  AST_PP_TAG:
    assert property (p_pp_tag) else $error("peripheral tag wrong");
  AST_CP_ADDR:
    assert property (cp_grant |=> mem_req && mem_addr == $past(cp_addr[MEM_ADDR_W-1:0]))
    else $error("stage one address wrong");
  AST_ONE_GRANT:
    assert property (!(cp_grant && pp_grant)) else $error("two grants at once");
  AST_HALT_NO_CP:
    assert property (cpu_halt |-> !cp_grant) else $error("central grant while halted");
  AST_DONE_PULSE:
    assert property (xchg_complete |=> !xchg_complete) else $error("complete not a pulse");
  AST_GO_LOAD:
    assert property (mem_go |-> ##[3:5] mem_req) else $error("no load after memory go");
  AST_GO_PULSE:
    assert property (mem_go |=> !mem_go[*2]) else $error("memory go not a pulse");
  cover property (pp_grant);
  cover property (mem_go);
  cover property (xchg_complete);
endmodule
bind mrhx_hopper mrhx_hopper_chk #(.ADDRW(ADDRW)) u_chk (.mclk, .rst_n, .cp_addr, .cp_fdes_tag,
  .cp_tag_from_cpu, .cp_cpu_tag, .cp_grant, .pp_write, .pp_grant, .xchg_complete, .cpu_halt,
  .mem_go, .mem_req, .mem_addr, .tag_s4, .tag_s3, .tag_s2);
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the memory request hopper
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mrhx_pkg::*;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic cp_req = 1'h0, cp_tag_from_cpu = 1'h0, pp_req = 1'h0, pp_write = 1'h0, reject = 1'h0;
  logic pp_xchg_pulse = 1'h0, cpu_running = 1'h0, issue = 1'h0, reservations_busy = 1'h0;
  logic [1:0] parcel_cnt = 2'h0;
  logic [ADDR_W-1:0] cp_addr = 18'h0, pp_addr = 18'h0, pc_value = 18'h2ABCD;
  logic [TAG_W-1:0] cp_fdes_tag = 6'h0, cp_cpu_tag = 6'h0;
  logic cp_grant, pp_grant, xchg_complete, cpu_halt, pc_to_word, mem_go, mem_req, mem_accept;
  logic pc_load;
  logic [MEM_ADDR_W-1:0] mem_addr;
  logic [TAG_W-1:0] tag_s4, tag_s3, tag_s2;
  logic [ADDR_W-1:0] pc_word_data;
  int bad_count = 0, tests_run = 0, cyc = 0, go_cnt = 0;
  mrhx_hopper dut (.mclk, .rst_n, .cp_req, .cp_addr, .cp_fdes_tag, .cp_tag_from_cpu, .cp_cpu_tag,
    .cp_grant, .pp_req, .pp_write, .pp_addr, .pp_xchg_pulse, .pp_grant, .xchg_complete,
    .cpu_running, .issue, .parcel_cnt, .reservations_busy, .pc_value, .cpu_halt, .pc_to_word,
    .pc_load, .mem_go, .mem_req, .mem_addr, .mem_accept, .tag_s4, .tag_s3, .tag_s2,
    .pc_word_data);
  mrhx_mem_model mem (.mclk, .rst_n, .mem_req, .reject, .mem_accept);
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  task automatic stop_test;
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ceiling well above the roughly 300 cycles the scenarios need
  always @(posedge mclk)
  begin
    cyc++;
    if (mem_go === 1'h1)
      go_cnt++;
    if (cyc == 5000)
    begin
      bad_count++;
      stop_test();
    end
  end
  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'h1 && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
    chk(s, 1'h1);
  endtask
  task automatic t_cp(input logic [ADDR_W-1:0] a, input logic fc, input logic [TAG_W-1:0] t,
    input logic rj);
    int n;
    step();
    cp_addr = a;
    cp_tag_from_cpu = fc;
    cp_fdes_tag = fc ? ~t : t;
    cp_cpu_tag = fc ? t : ~t;
    cp_req = 1'h1;
    @(negedge mclk);
    wait_hi(cp_grant, 50);
    step();
    cp_req = 1'h0;
    reject = rj;
    @(negedge mclk);
    chk(mem_addr, a[MEM_ADDR_W-1:0]);
    if (rj)
    begin
      repeat (3) step();
      reject = 1'h0;
      n = 0;
      @(negedge mclk);
      while (mem_req !== 1'h1 && n < 60)
      begin
        @(negedge mclk);
        n++;
      end
      chk(n, REISSUE_CYC - 3);
      chk(mem_addr, a[MEM_ADDR_W-1:0]);
    end
    @(negedge mclk);
    chk(tag_s4, t);
  endtask
  task automatic t_pp(input logic w);
    step();
    pp_addr = 18'h1F0F0;
    pp_write = w;
    pp_req = 1'h1;
    cp_req = 1'h1;
    @(negedge mclk);
    wait_hi(cp_grant, 50);
    chk(pp_grant, 1'h0);
    step();
    cp_req = 1'h0;
    @(negedge mclk);
    wait_hi(pp_grant, 50);
    step();
    pp_req = 1'h0;
    @(negedge mclk);
    chk(mem_addr, 17'h1F0F0);
  endtask
  task automatic t_xchg;
    int n;
    step();
    pp_addr = 18'h2FFF8;
    cpu_running = 1'h1;
    reservations_busy = 1'h1;
    pp_xchg_pulse = 1'h1;
    repeat (2) step();
    pp_xchg_pulse = 1'h0;
    parcel_cnt = 2'h2;
    issue = 1'h1;
    repeat (20) step();
    chk(cpu_halt, 1'h0);
    parcel_cnt = PARCEL_ONE;
    step();
    issue = 1'h0;
    repeat (20) step();
    chk(cpu_halt, 1'h1);
    chk(go_cnt, 0);
    reservations_busy = 1'h0;
    wait_hi(mem_go, 60);
    for (int i = 0; i < 16; i++)
    begin
      n = 0;
      @(negedge mclk);
      while (mem_req !== 1'h1 && n < 60)
      begin
        @(negedge mclk);
        n++;
      end
      chk(mem_req === 1'h1 && (i == 0 || n >= ISSUE_CYC - 2), 1'h1);
      chk(mem_addr, MEM_ADDR_W'(pp_addr + i));
      @(negedge mclk);
      chk(tag_s4, i);
    end
    wait_hi(xchg_complete, 400);
    chk(go_cnt, 1);
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    #1;
    rst_n = 1'h1;
    t_cp(18'h3FFFF, 1'h0, 6'h15, 1'h0);
    t_cp(18'h20001, 1'h1, 6'h2A, 1'h0);
    t_cp(18'h00ABC, 1'h0, 6'h07, 1'h1);
    t_pp(1'h0);
    t_pp(1'h1);
    t_cp(18'h0F00F, 1'h0, TAG_PC_SWAP, 1'h0);
    wait_hi(pc_to_word, 20);
    chk(pc_load, 1'h1);
    chk(pc_word_data, pc_value);
    t_xchg();
    repeat (5) step();
    stop_test();
  end
endmodule
`default_nettype wire
